// [hdl/jpw_jack_pins.sv]
// verb decode and control state for the line-in and headphone jack nodes
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R1: line-in pin capability read returns reference capability 0x17.
// R2: line-in output_capable bit 4 is 1 only while second converter enabled.
// R3: line-in connection count is 01h with second converter enabled, else 00h.
// R4: connection length bit 7 is 0 on both jacks: short entries.
// R5: line-in first list entry is 11h when second converter enabled, else 00h.
// R6: path and event set verbs write masked payload into bits 7..0; every set verb answers all zero.
// R7: path control bit 6 enables output path; resets to 0.
// R8: path control bit 5 enables input path; resets to 0.
// R9: line-in reference select keeps advertised codes, stores 000b for others.
// R10: headphone path bit 7 enables low impedance amp; bits 4..0 reserved.
// R11: headphone pin capability reports reference capability 0x00.
// R12: headphone reports headphone amp bit 3 set, line-in reports it clear.
// R13: event enable bit 7 sends async responses on insertion and sense done.
// R14: six-bit tag sits in bits 31..26 of every async response.
// R15: jack sense read shows bit 31 set while the jack is occupied.
// R16: impedance field is all ones when invalid or measuring; resets so.
// R17: sense write starts measuring; payload bit 0 picks ring, else tip.
// R18: controller must trigger sensing before trusting an impedance value.
// R19: line-in configuration default resets to 0x0181304e.
// R20: configuration bit 8 is the jack-detect override flag.
// R21: software avoids association 0000b and keeps sequence numbers unique.
// R22: headphone widget capability read returns pin complex word 0x00400181.
// R23: four configuration sets write bytes lowest first; no reserved bits.
// R24: line-in node answers at identifier 0x0c.
// R25: headphone list holds one entry 0x10, count 0x01.
module jpw_jack_pins
  import jpw_pkg::*;
(
  // core clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link clock and reset
  input wire logic link_clk,
  input wire logic link_rst_n,
  // verb request, link domain
  input wire logic verb_valid,
  output wire logic verb_ready,
  input wire logic [7:0] verb_nid,
  input wire logic [11:0] verb_id,
  input wire logic [7:0] verb_payload,
  // response, link domain
  output wire logic resp_valid,
  output wire logic [31:0] resp_data,
  output wire logic resp_unsol,
  // converter status, core domain
  input wire logic second_converter_enable,
  // jack presence pins, index 0 line-in, 1 headphone
  input wire logic [1:0] jack_occupied_pin,
  // impedance sense engine
  output wire logic [1:0] sense_start,
  output wire logic [1:0] sense_ring_select,
  input wire logic [1:0] sense_done,
  input wire logic [30:0] sense_value,
  // line-in path controls
  output wire logic line_in_output_path_enable,
  output wire logic line_in_input_path_enable,
  output wire logic [2:0] line_in_reference_select,
  output wire logic line_in_detect_override,
  // headphone path controls
  output wire logic headphone_low_impedance_amp_enable,
  output wire logic headphone_output_path_enable,
  output wire logic headphone_input_path_enable
);

  // link side state
  logic verb_ready_r;
  logic link_req_tgl_r;
  logic link_ack_tgl_r;
  logic [7:0] cmd_nid_r;
  logic [11:0] cmd_id_r;
  logic [7:0] cmd_pay_r;
  logic [2:0] resp_sync_r;
  logic resp_valid_r;
  logic [31:0] resp_data_r;
  logic resp_unsol_r;
  logic verb_ready_nxt;

  // core side state
  logic [2:0] req_sync_r;
  logic [1:0] ack_sync_r;
  logic cmd_pend_r;
  logic cmd_pend_nxt;
  logic core_resp_tgl_r;
  logic [31:0] core_resp_word_r;
  logic core_resp_unsol_r;
  logic [31:0] cfg_r;
  logic [31:0] cfg_nxt;

  // per jack state
  logic [7:0] path_r [2];
  logic [7:0] event_r [2];
  logic [30:0] imp_r [2];
  logic [2:0] occ_sync_r [2];
  logic unsol_pend_r [2];
  logic start_r [2];
  logic ring_r [2];

  // link side: take a verb, present the answer
  wire verb_take = verb_valid & verb_ready_r;
  wire resp_seen = resp_sync_r[2] ^ resp_sync_r[1];

  assign verb_ready_nxt = (verb_ready_r & ~verb_take) | (resp_seen & ~core_resp_unsol_r);

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      verb_ready_r <= 1'b1;
      link_req_tgl_r <= 1'b0;
      link_ack_tgl_r <= 1'b0;
      cmd_nid_r <= 8'h00;
      cmd_id_r <= 12'h000;
      cmd_pay_r <= 8'h00;
      resp_sync_r <= 3'b000;
      resp_valid_r <= 1'b0;
      resp_data_r <= JPW_RESP_ZERO;
      resp_unsol_r <= 1'b0;
    end else begin
      resp_sync_r <= {resp_sync_r[1:0], core_resp_tgl_r};
      resp_valid_r <= resp_seen;
      verb_ready_r <= verb_ready_nxt;
      if (verb_take) begin
        cmd_nid_r <= verb_nid;
        cmd_id_r <= verb_id;
        cmd_pay_r <= verb_payload;
        link_req_tgl_r <= ~link_req_tgl_r;
      end
      if (resp_seen) begin
        resp_data_r <= core_resp_word_r;
        resp_unsol_r <= core_resp_unsol_r;
        link_ack_tgl_r <= ~link_ack_tgl_r;
      end
    end
  end

  // core side: request and ack crossings
  wire req_seen = req_sync_r[2] ^ req_sync_r[1];
  wire resp_busy = core_resp_tgl_r ^ ack_sync_r[1];
  wire cmd_go = cmd_pend_r & ~resp_busy;
  wire any_unsol = unsol_pend_r[0] | unsol_pend_r[1];
  wire unsol_go = ~cmd_pend_r & ~resp_busy & any_unsol;
  wire unsol_sel = ~unsol_pend_r[0];

  assign cmd_pend_nxt = req_seen | (cmd_pend_r & ~cmd_go);

  // node and verb decode
  wire hit_line_in = cmd_nid_r == JPW_NID_LINE_IN; // R24
  wire hit_headphone = cmd_nid_r == JPW_NID_HEADPHONE;
  wire hit_any = hit_line_in | hit_headphone;
  wire jack_sel = hit_headphone;
  wire [1:0] hit_jack = {hit_headphone, hit_line_in};
  wire is_set_path = cmd_id_r == JPW_VERB_SET_PATH;
  wire is_set_event = cmd_id_r == JPW_VERB_SET_EVENT;
  wire is_set_sense = cmd_id_r == JPW_VERB_SET_SENSE;
  wire sce = second_converter_enable;

  // capability words
  wire [7:0] out_cap_bit = 8'(sce) << JPW_PIN_CAP_OUT_BIT; // R2
  wire [7:0] line_in_cap_low = JPW_PIN_CAP_COMMON | out_cap_bit; // R12
  wire [7:0] hp_cap_low = JPW_PIN_CAP_COMMON | (8'h01 << JPW_PIN_CAP_OUT_BIT)
    | (8'h01 << JPW_PIN_CAP_HP_BIT); // R12
  wire [31:0] pin_cap_line_in = {16'h0000, JPW_REF_CAP_LINE_IN, line_in_cap_low}; // R1
  wire [31:0] pin_cap_hp = {16'h0000, JPW_REF_CAP_HEADPHONE, hp_cap_low}; // R11
  wire [6:0] line_in_count = sce ? JPW_CONN_COUNT_ONE : JPW_CONN_COUNT_NONE; // R3
  wire [31:0] conn_len_line_in = {24'h000000, JPW_WIDE_ENTRY_FORM, line_in_count}; // R4
  wire [31:0] conn_len_hp = {24'h000000, JPW_WIDE_ENTRY_FORM, JPW_CONN_COUNT_ONE}; // R4
  wire [7:0] line_in_entry = sce ? JPW_ENTRY_SECOND_CONVERTER : JPW_ENTRY_UNUSED; // R5
  wire [31:0] list_line_in = {24'h000000, line_in_entry}; // R5
  wire [31:0] list_hp = {24'h000000, JPW_ENTRY_FIRST_CONVERTER}; // R25
  wire first_index = cmd_pay_r == JPW_LIST_INDEX_FIRST;

  // parameter read selection
  wire [31:0] param_pin = hit_line_in ? pin_cap_line_in :
    (hit_headphone ? pin_cap_hp : JPW_RESP_ZERO);
  wire [31:0] param_len = hit_line_in ? conn_len_line_in :
    (hit_headphone ? conn_len_hp : JPW_RESP_ZERO);
  wire [31:0] param_widget_capabilities = hit_headphone ? JPW_WIDGET_CAP_HEADPHONE : JPW_RESP_ZERO; // R22
  wire [31:0] param_word =
    (cmd_pay_r == JPW_PARAM_PIN_CAP) ? param_pin :
    (cmd_pay_r == JPW_PARAM_CONN_LEN) ? param_len :
    (cmd_pay_r == JPW_PARAM_WIDGET_CAP) ? param_widget_capabilities : JPW_RESP_ZERO;
  wire [31:0] list_word = !first_index ? JPW_RESP_ZERO :
    (hit_line_in ? list_line_in : (hit_headphone ? list_hp : JPW_RESP_ZERO));

  // state reads
  wire [31:0] path_word = {24'h000000, path_r[jack_sel]};
  wire [31:0] event_word = {24'h000000, event_r[jack_sel]};
  wire [31:0] sense_word = {occ_sync_r[jack_sel][2], imp_r[jack_sel]}; // R15
  wire [31:0] cfg_word = hit_line_in ? cfg_r : JPW_RESP_ZERO;

  // answer word; every set and unknown verb answers zero
  wire [31:0] get_word =
    (cmd_id_r == JPW_VERB_GET_PARAM) ? param_word :
    (cmd_id_r == JPW_VERB_GET_CONN_LIST) ? list_word :
    (cmd_id_r == JPW_VERB_GET_PATH && hit_any) ? path_word :
    (cmd_id_r == JPW_VERB_GET_EVENT && hit_any) ? event_word :
    (cmd_id_r == JPW_VERB_GET_SENSE && hit_any) ? sense_word :
    (cmd_id_r == JPW_VERB_GET_CONFIG) ? cfg_word : JPW_RESP_ZERO; // R6

  // async response word
  wire [31:0] unsol_word = {event_r[unsol_sel][JPW_TAG_W-1:0], {JPW_UNSOL_PAD_W{1'b0}}}; // R14

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      req_sync_r <= 3'b000;
      ack_sync_r <= 2'b00;
      cmd_pend_r <= 1'b0;
      core_resp_tgl_r <= 1'b0;
      core_resp_word_r <= JPW_RESP_ZERO;
      core_resp_unsol_r <= 1'b0;
      cfg_r <= JPW_CONFIG_LINE_IN_RESET; // R19
    end else begin
      req_sync_r <= {req_sync_r[1:0], link_req_tgl_r};
      ack_sync_r <= {ack_sync_r[0], link_ack_tgl_r};
      cmd_pend_r <= cmd_pend_nxt;
      cfg_r <= cfg_nxt;
      if (cmd_go) begin
        core_resp_word_r <= get_word;
        core_resp_unsol_r <= 1'b0;
        core_resp_tgl_r <= ~core_resp_tgl_r;
      end else if (unsol_go) begin
        core_resp_word_r <= unsol_word;
        core_resp_unsol_r <= 1'b1;
        core_resp_tgl_r <= ~core_resp_tgl_r;
      end
    end
  end

  // configuration default byte writes, lowest byte first
  genvar k;
  generate
    for (k = 0; k < JPW_CONFIG_BYTES; k++) begin : g_cfg
      wire cfg_wr = cmd_go & hit_line_in & (cmd_id_r == JPW_VERB_SET_CONFIG_FIRST + 12'(k));
      assign cfg_nxt[8*k +: 8] = cfg_wr ? cmd_pay_r : cfg_r[8*k +: 8]; // R23
    end
  endgenerate

  // per jack control, sense and event logic
  genvar j;
  generate
    for (j = 0; j < 2; j++) begin : g_jack
      wire [7:0] path_mask = (j == 0) ? JPW_PATH_MASK_LINE_IN : JPW_PATH_MASK_HEADPHONE; // R10
      wire [7:0] ref_cap = (j == 0) ? JPW_REF_CAP_LINE_IN : JPW_REF_CAP_HEADPHONE;
      wire [2:0] ref_req = cmd_pay_r[JPW_REF_SEL_W-1:0];
      wire [2:0] ref_fix = ref_cap[ref_req] ? ref_req : JPW_REF_HIZ; // R9
      wire [7:0] path_wr = {cmd_pay_r[7:3] & path_mask[7:3], ref_fix & path_mask[2:0]};
      wire wr_path = cmd_go & hit_jack[j] & is_set_path; // R6
      wire wr_event = cmd_go & hit_jack[j] & is_set_event; // R6
      wire trigger = cmd_go & hit_jack[j] & is_set_sense; // R17
      wire inserted = occ_sync_r[j][1] & ~occ_sync_r[j][2];
      wire event_hit = (inserted | sense_done[j]) & event_r[j][JPW_EVENT_EN_BIT]; // R13
      wire sent = unsol_go & (unsol_sel == 1'(j));

      always_ff @(posedge clock) begin
        if (!rst_n) begin
          path_r[j] <= JPW_PATH_RESET; // R7 R8
          event_r[j] <= JPW_EVENT_RESET;
          imp_r[j] <= JPW_IMP_INVALID; // R16
          occ_sync_r[j] <= 3'b000;
          unsol_pend_r[j] <= 1'b0;
          start_r[j] <= 1'b0;
          ring_r[j] <= 1'b0;
        end else begin
          occ_sync_r[j] <= {occ_sync_r[j][1:0], jack_occupied_pin[j]};
          start_r[j] <= trigger; // R17
          unsol_pend_r[j] <= event_hit | (unsol_pend_r[j] & ~sent);
          if (wr_path) begin
            path_r[j] <= path_wr; // R7 R8 R10
          end
          if (wr_event) begin
            event_r[j] <= cmd_pay_r & JPW_EVENT_MASK;
          end
          if (trigger) begin
            imp_r[j] <= JPW_IMP_INVALID; // R16
            ring_r[j] <= cmd_pay_r[0]; // R17
          end else if (sense_done[j]) begin
            imp_r[j] <= sense_value;
          end
        end
      end
    end
  endgenerate

  // outputs
  assign verb_ready = verb_ready_r;
  assign resp_valid = resp_valid_r;
  assign resp_data = resp_data_r;
  assign resp_unsol = resp_unsol_r;
  assign sense_start = {start_r[1], start_r[0]};
  assign sense_ring_select = {ring_r[1], ring_r[0]};
  assign line_in_output_path_enable = path_r[0][JPW_PATH_OUT_BIT]; // R7
  assign line_in_input_path_enable = path_r[0][JPW_PATH_IN_BIT]; // R8
  assign line_in_reference_select = path_r[0][JPW_REF_SEL_W-1:0];
  assign line_in_detect_override = cfg_r[JPW_CONFIG_OVERRIDE_BIT]; // R20
  assign headphone_low_impedance_amp_enable = path_r[1][JPW_PATH_AMP_BIT]; // R10
  assign headphone_output_path_enable = path_r[1][JPW_PATH_OUT_BIT]; // R7
  assign headphone_input_path_enable = path_r[1][JPW_PATH_IN_BIT]; // R8

endmodule
`default_nettype wire

// [inc/jpw_pkg.sv]
// constants for the two jack pin widget nodes
package jpw_pkg;
  // node identifiers
  localparam logic [7:0] JPW_NID_LINE_IN = 8'h0c;
  localparam logic [7:0] JPW_NID_HEADPHONE = 8'h0d;
  // verb identifiers
  localparam logic [11:0] JPW_VERB_GET_PARAM = 12'hf00;
  localparam logic [11:0] JPW_VERB_GET_CONN_LIST = 12'hf02;
  localparam logic [11:0] JPW_VERB_GET_PATH = 12'hf07;
  localparam logic [11:0] JPW_VERB_SET_PATH = 12'h707;
  localparam logic [11:0] JPW_VERB_GET_EVENT = 12'hf08;
  localparam logic [11:0] JPW_VERB_SET_EVENT = 12'h708;
  localparam logic [11:0] JPW_VERB_GET_SENSE = 12'hf09;
  localparam logic [11:0] JPW_VERB_SET_SENSE = 12'h709;
  localparam logic [11:0] JPW_VERB_GET_CONFIG = 12'hf1c;
  localparam logic [11:0] JPW_VERB_SET_CONFIG_FIRST = 12'h71c;
  localparam int JPW_CONFIG_BYTES = 4;
  // parameter identifiers for the get parameter verb
  localparam logic [7:0] JPW_PARAM_WIDGET_CAP = 8'h09;
  localparam logic [7:0] JPW_PARAM_PIN_CAP = 8'h0c;
  localparam logic [7:0] JPW_PARAM_CONN_LEN = 8'h0e;
  // capability words and fields
  localparam logic [31:0] JPW_WIDGET_CAP_HEADPHONE = 32'h0040_0181;
  localparam logic [7:0] JPW_REF_CAP_LINE_IN = 8'h17;
  localparam logic [7:0] JPW_REF_CAP_HEADPHONE = 8'h00;
  localparam logic [7:0] JPW_PIN_CAP_COMMON = 8'h27;
  localparam int JPW_PIN_CAP_OUT_BIT = 4;
  localparam int JPW_PIN_CAP_HP_BIT = 3;
  localparam logic JPW_WIDE_ENTRY_FORM = 1'b0;
  localparam logic [6:0] JPW_CONN_COUNT_ONE = 7'h01;
  localparam logic [6:0] JPW_CONN_COUNT_NONE = 7'h00;
  localparam logic [7:0] JPW_ENTRY_SECOND_CONVERTER = 8'h11;
  localparam logic [7:0] JPW_ENTRY_FIRST_CONVERTER = 8'h10;
  localparam logic [7:0] JPW_ENTRY_UNUSED = 8'h00;
  localparam logic [7:0] JPW_LIST_INDEX_FIRST = 8'h00;
  // path control layout
  localparam logic [7:0] JPW_PATH_MASK_LINE_IN = 8'h67;
  localparam logic [7:0] JPW_PATH_MASK_HEADPHONE = 8'he0;
  localparam int JPW_PATH_AMP_BIT = 7;
  localparam int JPW_PATH_OUT_BIT = 6;
  localparam int JPW_PATH_IN_BIT = 5;
  localparam int JPW_REF_SEL_W = 3;
  localparam logic [2:0] JPW_REF_HIZ = 3'b000;
  localparam logic [2:0] JPW_REF_HALF = 3'b001;
  localparam logic [2:0] JPW_REF_GROUND = 3'b010;
  localparam logic [2:0] JPW_REF_EIGHTY = 3'b100;
  localparam logic [7:0] JPW_PATH_RESET = 8'h00;
  // event control layout
  localparam logic [7:0] JPW_EVENT_MASK = 8'hbf;
  localparam logic [7:0] JPW_EVENT_RESET = 8'h00;
  localparam int JPW_EVENT_EN_BIT = 7;
  localparam int JPW_TAG_W = 6;
  localparam int JPW_UNSOL_PAD_W = 26;
  // jack sense layout
  localparam int JPW_IMP_W = 31;
  localparam logic [30:0] JPW_IMP_INVALID = 31'h7fff_ffff;
  // configuration default
  localparam logic [31:0] JPW_CONFIG_LINE_IN_RESET = 32'h0181_304e;
  localparam int JPW_CONFIG_OVERRIDE_BIT = 8;
  localparam logic [31:0] JPW_RESP_ZERO = 32'h0000_0000;
endpackage

// [testbench/jpw_jack_pins_bench.sv]
// self-checking bench for the jack pin widget verb logic
`timescale 1ns/1ns
`default_nettype none
module jpw_jack_pins_bench import jpw_pkg::*;;
  logic clock = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic link_rst_n = 1'b0;
  logic sce = 1'b0;
  logic [1:0] occ = 2'b00;
  logic [1:0] done = 2'b00;
  logic [30:0] sval = 31'h0;
  wire logic vv, vr, rv, ru, lout, lin, lovr, hamp, hout, hin;
  wire logic [7:0] vn, vp;
  wire logic [11:0] vi;
  wire logic [31:0] rd;
  wire logic [1:0] sst, sring;
  wire logic [2:0] lref;
  int err_count = 0;
  int comparisons = 0;
  int starts = 0;
  always #4 clock = ~clock;
  always #6 link_clk = ~link_clk;
  // counts headphone sense start pulses
  always @(posedge clock) if (sst == 2'b10) starts <= starts + 1;
  jpw_jack_pins dut_u (.clock(clock), .rst_n(rst_n), .link_clk(link_clk),
    .link_rst_n(link_rst_n), .verb_valid(vv), .verb_ready(vr), .verb_nid(vn),
    .verb_id(vi), .verb_payload(vp), .resp_valid(rv), .resp_data(rd), .resp_unsol(ru),
    .second_converter_enable(sce), .jack_occupied_pin(occ), .sense_start(sst),
    .sense_ring_select(sring), .sense_done(done), .sense_value(sval),
    .line_in_output_path_enable(lout), .line_in_input_path_enable(lin),
    .line_in_reference_select(lref), .line_in_detect_override(lovr),
    .headphone_low_impedance_amp_enable(hamp), .headphone_output_path_enable(hout),
    .headphone_input_path_enable(hin));
  jpw_link_ctl_model ctl_u (.link_clk(link_clk), .verb_valid(vv), .verb_ready(vr),
    .verb_nid(vn), .verb_id(vi), .verb_payload(vp), .resp_valid(rv), .resp_data(rd),
    .resp_unsol(ru));
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic timeout;
    err_count++;
    $display("BAD %0t wait ran out", $time);
    end_of_test();
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk(input logic [7:0] n, input logic [11:0] v, input logic [7:0] p,
      input logic [31:0] e);
    logic [31:0] r;
    bit ok;
    ctl_u.xfer(n, v, p, r, ok);
    if (!ok) timeout();
    cmp(r, e);
  endtask
  task automatic t_caps;
    for (int s = 0; s < 2; s++) begin
      @(posedge clock);
      sce <= s[0];
      chk(8'h0c, 12'hf00, 8'h0c, {16'h0, 8'h17, 8'h27 | {3'b0, s[0], 4'h0}});
      chk(8'h0c, 12'hf00, 8'h0e, {24'h0, 7'h0, s[0]});
      chk(8'h0c, 12'hf02, 8'h00, {24'h0, s[0] ? 8'h11 : 8'h00});
    end
    chk(8'h0d, 12'hf00, 8'h0c, 32'h0000_003f);
    chk(8'h0d, 12'hf00, 8'h0e, 32'h0000_0001);
    chk(8'h0d, 12'hf02, 8'h00, 32'h0000_0010);
    chk(8'h0d, 12'hf00, 8'h09, 32'h0040_0181);
  endtask
  task automatic t_path;
    for (int c = 0; c < 8; c++) begin
      chk(8'h0c, 12'h707, 8'h58 | c[7:0], 32'h0);
      chk(8'h0c, 12'hf07, 8'h00, {24'h0, 8'h40 | (c inside {0, 1, 2, 4} ? c[7:0] : 8'h0)});
      cmp({29'h0, lout, lin, lref == (c inside {0, 1, 2, 4} ? c[2:0] : 3'b000)}, 32'h5);
    end
    chk(8'h0c, 12'h707, 8'h20, 32'h0);
    cmp({30'h0, lout, lin}, 32'h1);
    chk(8'h0d, 12'h707, 8'hff, 32'h0);
    chk(8'h0d, 12'hf07, 8'h00, 32'h0000_00e0);
    cmp({29'h0, hamp, hout, hin}, 32'h7);
  endtask
  task automatic t_sense;
    chk(8'h0d, 12'hf09, 8'h00, 32'h7fff_ffff);
    chk(8'h0d, 12'h709, 8'h01, 32'h0);
    cmp({30'h0, sring}, 32'h2);
    cmp(starts, 32'h1);
    @(posedge clock);
    done <= 2'b10;
    sval <= 31'h0000_1234;
    @(posedge clock);
    done <= 2'b00;
    sval <= 31'h5555_5555;
    chk(8'h0d, 12'hf09, 8'h00, 32'h0000_1234);
    chk(8'h0d, 12'h709, 8'h00, 32'h0);
    cmp({30'h0, sring}, 32'h0);
    cmp(starts, 32'h2);
    chk(8'h0d, 12'hf09, 8'h00, 32'h7fff_ffff);
  endtask
  task automatic t_cfg;
    logic [31:0] w = 32'h0181_3121;
    chk(8'h0c, 12'hf1c, 8'h00, 32'h0181_304e);
    cmp({31'h0, lovr}, 32'h0);
    for (int b = 0; b < 4; b++) chk(8'h0c, 12'h71c + b[11:0], w[8*b +: 8], 32'h0);
    chk(8'h0c, 12'hf1c, 8'h00, w);
    cmp({31'h0, lovr}, 32'h1);
    chk(8'h0e, 12'hf07, 8'h00, 32'h0);
  endtask
  task automatic t_event;
    int n;
    int i;
    chk(8'h0c, 12'h708, 8'hff, 32'h0);
    chk(8'h0c, 12'hf08, 8'h00, 32'h0000_00bf);
    chk(8'h0c, 12'hf09, 8'h00, 32'h7fff_ffff);
    n = ctl_u.unsol_cnt;
    @(posedge clock);
    occ <= 2'b01;
    for (i = 0; i < 60 && ctl_u.unsol_cnt == n; i++) @(posedge link_clk);
    if (i == 60) timeout();
    cmp(ctl_u.unsol_word, 32'hfc00_0000);
    chk(8'h0c, 12'hf09, 8'h00, 32'hffff_ffff);
    n = ctl_u.unsol_cnt;
    @(posedge clock);
    done <= 2'b01;
    sval <= 31'h0000_0abc;
    @(posedge clock);
    done <= 2'b00;
    for (i = 0; i < 60 && ctl_u.unsol_cnt == n; i++) @(posedge link_clk);
    if (i == 60) timeout();
    cmp(ctl_u.unsol_cnt - n, 32'h1);
    cmp(ctl_u.unsol_word, 32'hfc00_0000);
    chk(8'h0c, 12'hf09, 8'h00, 32'h8000_0abc);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge link_clk);
    link_rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_caps();
    t_path();
    t_sense();
    t_cfg();
    t_event();
    end_of_test();
  end
endmodule
`default_nettype wire

// [testbench/jpw_jack_pins_checker.sv]
// concurrent checks on the jack pin widget verb port
`timescale 1ns/1ns
`default_nettype none
module jpw_jack_pins_checker (
  // clocks and resets
  input wire logic clock,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic link_rst_n,
  // verb port
  input wire logic verb_valid,
  input wire logic verb_ready,
  input wire logic [11:0] verb_id,
  input wire logic resp_valid,
  input wire logic [31:0] resp_data,
  input wire logic resp_unsol,
  // core outputs
  input wire logic [1:0] sense_start,
  input wire logic [2:0] line_in_reference_select
);
  // remembers whether the verb in flight is a set
  logic set_r;
  always_ff @(posedge link_clk) begin
    if (!link_rst_n)
      set_r <= 1'b0;
    else if (verb_valid && verb_ready)
      set_r <= (verb_id[11:8] == 4'h7);
  end
  property p_take_drops;
    @(posedge link_clk) disable iff (!link_rst_n) verb_valid && verb_ready |=> !verb_ready;
  endproperty
  a_take_drops: assert property (p_take_drops) else $error("ready high after take");
  property p_answer_in_time;
    @(posedge link_clk) disable iff (!link_rst_n)
      verb_valid && verb_ready |-> ##[1:30] (resp_valid && !resp_unsol);
  endproperty
  a_answer_in_time: assert property (p_answer_in_time) else $error("no answer");
  property p_resp_pulse;
    @(posedge link_clk) disable iff (!link_rst_n) resp_valid |=> !resp_valid;
  endproperty
  a_resp_pulse: assert property (p_resp_pulse) else $error("response too long");
  property p_ready_back;
    @(posedge link_clk) disable iff (!link_rst_n)
      resp_valid && !resp_unsol |-> verb_ready && !$past(verb_ready);
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("ready not back");
  property p_set_zero;
    @(posedge link_clk) disable iff (!link_rst_n)
      resp_valid && !resp_unsol && set_r |-> resp_data == 32'h0000_0000;
  endproperty
  a_set_zero: assert property (p_set_zero) else $error("set answer not zero");
  property p_unsol_low;
    @(posedge link_clk) disable iff (!link_rst_n)
      resp_valid && resp_unsol |-> resp_data[25:0] == 26'h0 && !$rose(verb_ready);
  endproperty
  a_unsol_low: assert property (p_unsol_low) else $error("async word bad");
  property p_sense_pulse;
    @(posedge clock) disable iff (!rst_n) sense_start != 2'b00 |=> sense_start == 2'b00;
  endproperty
  a_sense_pulse: assert property (p_sense_pulse) else $error("start too long");
  property p_ref_legal;
    @(posedge clock) disable iff (!rst_n)
      $changed(line_in_reference_select) |-> line_in_reference_select inside {0, 1, 2, 4};
  endproperty
  a_ref_legal: assert property (p_ref_legal) else $error("bad reference code");
endmodule
bind jpw_jack_pins jpw_jack_pins_checker chk_u (.clock(clock), .rst_n(rst_n),
  .link_clk(link_clk), .link_rst_n(link_rst_n), .verb_valid(verb_valid),
  .verb_ready(verb_ready), .verb_id(verb_id), .resp_valid(resp_valid),
  .resp_data(resp_data), .resp_unsol(resp_unsol), .sense_start(sense_start),
  .line_in_reference_select(line_in_reference_select));
`default_nettype wire

// [testbench/jpw_link_ctl_model.sv]
// controller model: issues verbs, catches async responses
`timescale 1ns/1ns
`default_nettype none
module jpw_link_ctl_model (
  // link side
  input wire logic link_clk,
  output var logic verb_valid,
  input wire logic verb_ready,
  output var logic [7:0] verb_nid,
  output var logic [11:0] verb_id,
  output var logic [7:0] verb_payload,
  // responses
  input wire logic resp_valid,
  input wire logic [31:0] resp_data,
  input wire logic resp_unsol
);
  logic [31:0] unsol_word = 32'h0;
  int unsol_cnt = 0;
  initial begin
    verb_valid = 1'b0;
    verb_nid = 8'h55;
    verb_id = 12'h555;
    verb_payload = 8'h55;
  end
  always @(posedge link_clk) begin
    if (resp_valid && resp_unsol) begin
      unsol_word <= resp_data;
      unsol_cnt <= unsol_cnt + 1;
    end
  end
  // one verb outstanding; fields scrambled once taken
  task automatic xfer(input logic [7:0] n, input logic [11:0] v, input logic [7:0] p,
      output logic [31:0] r, output bit ok);
    int i;
    ok = 1'b0;
    r = 32'h0;
    @(posedge link_clk);
    verb_valid <= 1'b1;
    verb_nid <= n;
    verb_id <= v;
    verb_payload <= p;
    for (i = 0; i < 40; i++) begin
      @(posedge link_clk);
      if (verb_ready) break;
    end
    verb_valid <= 1'b0;
    verb_nid <= ~n;
    verb_id <= ~v;
    verb_payload <= ~p;
    for (int k = 0; k < 40 && i < 40 && !ok; k++) begin
      @(posedge link_clk);
      if (resp_valid && !resp_unsol) begin
        r = resp_data;
        ok = 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire
